// [line_exposure_defines.vh]
// constants for the line exposure timing block
// Functional notes
// - free-run rate change shortens exposure to fit
// - free-run exposure range bounded by line period
// - never generate line period below readout period
// - pulse-width mode: rise exposes, fall starts readout
// - timed external mode: falling edge starts programmed exposure
// - latch one extra falling edge during exposure
// - line period accepted only with triggering disabled
// - reject period not above minimum exposure plus low time
// - over-speed triggers dropped, line rate capped
// - programmed line rate between 1 Hz and 48 kHz
// - 8K sensor caps rate by link and format
// - 4K sensor caps rate by link and format
// - exposure written except in pulse-width mode, 4-3000us
// - pulse-width mode only while triggering enabled
// - line sync arrives on first control line, sampled
`ifndef LINE_EXPOSURE_DEFINES_VH
`define LINE_EXPOSURE_DEFINES_VH

// ****************************************
// clock and timing
// ****************************************
`define CLOCK_HZ 25000000
`define CLOCK_NS 40
`define READOUT_NS 20300
`define READOUT_CYCLES ((`READOUT_NS + `CLOCK_NS - 1) / `CLOCK_NS)
`define MIN_LOW_NS 2000
`define MIN_LOW_CYCLES ((`MIN_LOW_NS + `CLOCK_NS - 1) / `CLOCK_NS)
`define EXPOSURE_MIN_NS 4000
`define EXPOSURE_MIN_CYCLES ((`EXPOSURE_MIN_NS + `CLOCK_NS - 1) / `CLOCK_NS)
`define EXPOSURE_MAX_US 3000
`define EXPOSURE_MAX_CYCLES ((`EXPOSURE_MAX_US * 1000) / `CLOCK_NS)
`define LINE_RATE_MIN_HZ 1
`define LINE_PERIOD_MAX_CYCLES (`CLOCK_HZ / `LINE_RATE_MIN_HZ)
`define PERIOD_OF(hz) ((`CLOCK_HZ + (hz) - 1) / (hz))

// ****************************************
// line rate caps in hertz
// ****************************************
`define RATE_10K 10000
`define RATE_20K 20000
`define RATE_23K 23000
`define RATE_27K 27000
`define RATE_34K 34000
`define RATE_40K 40000
`define RATE_46K 46000
`define RATE_48K 48000

// ****************************************
// register offsets
// ****************************************
`define OFF_CONTROL 8'h00
`define OFF_LINE_PERIOD 8'h04
`define OFF_EXPOSURE 8'h08
`define OFF_STATUS 8'h0c
`define OFF_MASK 8'h10
`define OFF_STATE 8'h14

// ****************************************
// control fields, link and format codes
// ****************************************
`define CTRL_TRIGGER 0
`define CTRL_WIDTH 1
`define CTRL_LINK_LSB 2
`define CTRL_FORMAT_LSB 4
`define CTRL_SENSOR_8K 6
`define LINK_BASE 2'h0
`define LINK_MEDIUM 2'h1
`define LINK_FULL 2'h2
`define LINK_DECA 2'h3
`define colour_8bit_format 2'h0
`define colour_12bit_format 2'h1
`define interleaved_8bit_format 2'h2
`define green_only_8bit_format 2'h3

// ****************************************
// status bits, reset values, responses
// ****************************************
`define ST_LINE_START 0
`define ST_READOUT 1
`define ST_INVALID 2
`define ST_DROPPED 3
`define STATUS_W 4
`define RESET_LINE_PERIOD 25'h00061a8
`define RESET_EXPOSURE 25'h00003e8
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [line_exposure_timing.v]
// line exposure and readout timing engine with its register file
`timescale 1ns/10ps
`include "line_exposure_defines.vh"

module line_exposure_timing #(
    parameter ADDR_W = 8,
    parameter PERIOD_W = 25,
    parameter [PERIOD_W-1:0] LINE_PERIOD_MAX = `LINE_PERIOD_MAX_CYCLES,
    parameter [PERIOD_W-1:0] EXPOSURE_MAX = `EXPOSURE_MAX_CYCLES
)(
    // clock, reset, clock enable
    input wire clock,
    input wire reset,
    input wire enable,
    // line sync from the frame grabber
    input wire line_sync_input,
    // axi4-lite write
    input wire [ADDR_W-1:0] awaddr,
    input wire awvalid,
    output reg awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output reg wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    // axi4-lite read
    input wire [ADDR_W-1:0] araddr,
    input wire arvalid,
    output reg arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    // sensor timing and interrupt
    output reg exposure_active,
    output reg line_start,
    output reg readout_start,
    output reg irq
);

    // ****************************************
    // cycle constants
    // ****************************************
    localparam [PERIOD_W-1:0] readout_cycles = `READOUT_CYCLES;
    localparam [PERIOD_W-1:0] min_low = `MIN_LOW_CYCLES;
    localparam [PERIOD_W-1:0] exposure_min = `EXPOSURE_MIN_CYCLES;
    localparam [PERIOD_W-1:0] p10k = `PERIOD_OF(`RATE_10K);
    localparam [PERIOD_W-1:0] p20k = `PERIOD_OF(`RATE_20K);
    localparam [PERIOD_W-1:0] p23k = `PERIOD_OF(`RATE_23K);
    localparam [PERIOD_W-1:0] p27k = `PERIOD_OF(`RATE_27K);
    localparam [PERIOD_W-1:0] p34k = `PERIOD_OF(`RATE_34K);
    localparam [PERIOD_W-1:0] p40k = `PERIOD_OF(`RATE_40K);
    localparam [PERIOD_W-1:0] p46k = `PERIOD_OF(`RATE_46K);
    localparam [PERIOD_W-1:0] p48k = `PERIOD_OF(`RATE_48K);

    // ****************************************
    // state
    // ****************************************
    reg trigger_on;
    reg width_mode;
    reg sensor_8k;
    reg [1:0] link_cfg;
    reg [1:0] pixel_fmt;
    reg [PERIOD_W-1:0] line_period;
    reg [PERIOD_W-1:0] exposure;
    reg [`STATUS_W-1:0] status;
    reg [`STATUS_W-1:0] mask;
    reg aw_held;
    reg w_held;
    reg [ADDR_W-1:0] waddr;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg sync_meta;
    reg sync_s;
    reg sync_prev;
    reg pending;
    reg [PERIOD_W-1:0] exp_count;
    reg [PERIOD_W-1:0] period_count;
    reg [PERIOD_W-1:0] since_line;

    // ****************************************
    // register read mux
    // ****************************************
    function [32:0] read_word;
        input [ADDR_W-1:0] a;
        begin
            read_word = 33'h0;
            case (a)
                `OFF_CONTROL:
                begin
                    read_word[`CTRL_TRIGGER] = trigger_on;
                    read_word[`CTRL_WIDTH] = width_mode;
                    read_word[`CTRL_LINK_LSB +: 2] = link_cfg;
                    read_word[`CTRL_FORMAT_LSB +: 2] = pixel_fmt;
                    read_word[`CTRL_SENSOR_8K] = sensor_8k;
                end
                `OFF_LINE_PERIOD: read_word[PERIOD_W-1:0] = line_period;
                `OFF_EXPOSURE: read_word[PERIOD_W-1:0] = exposure;
                `OFF_STATUS: read_word[`STATUS_W-1:0] = status;
                `OFF_MASK: read_word[`STATUS_W-1:0] = mask;
                `OFF_STATE: read_word[4:0] = {sync_s, pending, exposure_active,
                                              width_mode, trigger_on};
                default: read_word[32] = 1'b1;
            endcase
        end
    endfunction

    // ****************************************
    // write decode and parameter checks
    // ****************************************
    wire [32:0] cur_word = read_word(waddr);
    wire [31:0] byte_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}},
                             {8{wstrb_q[0]}}};
    wire [31:0] merged = (cur_word[31:0] & ~byte_mask) | (wdata_q & byte_mask);
    wire do_write = aw_held & w_held & ~bvalid;
    wire [PERIOD_W-1:0] new_val = merged[PERIOD_W-1:0];
    wire high_clear = ~|merged[31:PERIOD_W];
    wire width_eff = trigger_on & width_mode;
    reg [PERIOD_W-1:0] cap_period;
    always @*
    begin
        case (link_cfg)
            `LINK_BASE: cap_period = sensor_8k ? p10k : p20k;
            `LINK_MEDIUM:
            begin
                if (pixel_fmt == `colour_12bit_format)
                    cap_period = sensor_8k ? p23k : p46k;
                else
                    cap_period = sensor_8k ? p20k : p40k;
            end
            `LINK_FULL:
            begin
                if (sensor_8k && pixel_fmt != `green_only_8bit_format)
                    cap_period = p27k;
                else
                    cap_period = p48k;
            end
            default:
            begin
                if (sensor_8k && pixel_fmt != `interleaved_8bit_format)
                    cap_period = p34k;
                else
                    cap_period = p48k;
            end
        endcase
    end
    // shortest line the engine will make, never under readout or 48 kHz
    wire [PERIOD_W-1:0] min_period = (cap_period > readout_cycles) ? cap_period :
                                     readout_cycles;
    wire [PERIOD_W:0] new_exp_low = {1'b0, new_val} + {1'b0, min_low};
    wire [PERIOD_W:0] floor_low = {1'b0, exposure_min} + {1'b0, min_low};
    wire period_ok = ~trigger_on & high_clear
                     & (new_val >= min_period) & (new_val >= p48k)
                     & (new_val <= LINE_PERIOD_MAX)
                     & ({1'b0, new_val} > floor_low);
    wire exposure_ok = ~width_eff & high_clear
                       & (new_val >= exposure_min) & (new_val <= EXPOSURE_MAX)
                       & ({1'b0, line_period} > new_exp_low);
    wire [PERIOD_W-1:0] fit_limit = new_val - min_low - 1'b1;
    wire [PERIOD_W-1:0] exposure_fit = (exposure > fit_limit) ? fit_limit :
                                       exposure;
    wire wr_control = do_write & (waddr == `OFF_CONTROL);
    wire wr_period = do_write & (waddr == `OFF_LINE_PERIOD);
    wire wr_exposure = do_write & (waddr == `OFF_EXPOSURE);
    wire ev_invalid = (wr_period & ~period_ok) | (wr_exposure & ~exposure_ok);

    // ****************************************
    // exposure engine decisions
    // ****************************************
    wire rise = sync_s & ~sync_prev;
    wire fall = ~sync_s & sync_prev;
    wire ready_new = since_line >= min_period - 1'b1;
    wire free_run = ~trigger_on;
    wire timed_ext = trigger_on & ~width_mode;
    // a period left below a tighter link cap is stretched to the cap
    wire free_start = free_run & (period_count >= line_period - 1'b1)
                      & ready_new;
    wire timed_start = timed_ext & ~exposure_active & ready_new
                       & (pending | fall);
    wire width_start = width_eff & rise & ~exposure_active & ready_new;
    wire ev_line = free_start | timed_start | width_start;
    wire timed_end = ~width_eff & exposure_active & (exp_count <= 1);
    wire width_end = width_eff & exposure_active & fall;
    wire ev_readout = timed_end | width_end;
    // a third edge, or a width pulse arriving too soon, is surplus
    wire ev_dropped = (timed_ext & fall & pending & ~timed_start)
                      | (width_eff & rise & ~width_start);
    wire [`STATUS_W-1:0] ev_set;
    assign ev_set[`ST_LINE_START] = ev_line;
    assign ev_set[`ST_READOUT] = ev_readout;
    assign ev_set[`ST_INVALID] = ev_invalid;
    assign ev_set[`ST_DROPPED] = ev_dropped;
    wire [`STATUS_W-1:0] clear_bits = (do_write & (waddr == `OFF_STATUS)) ?
                                      (wdata_q[`STATUS_W-1:0] & byte_mask[`STATUS_W-1:0]) :
                                      {`STATUS_W{1'b0}};
    // a set in the cycle of its clear wins
    wire [`STATUS_W-1:0] next_status = (status & ~clear_bits) | ev_set;

    // ****************************************
    // axi4-lite slave
    // ****************************************
    always @(posedge clock)
    begin
        if (reset)
        begin
            awready <= 1'b1;
            wready <= 1'b1;
            arready <= 1'b1;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            bvalid <= 1'b0;
            rvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            rresp <= `RESP_OKAY;
            rdata <= 32'h00000000;
            waddr <= {ADDR_W{1'b0}};
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end
        else if (enable)
        begin
            if (awvalid & awready)
            begin
                aw_held <= 1'b1;
                awready <= 1'b0;
                waddr <= awaddr;
            end
            if (wvalid & wready)
            begin
                w_held <= 1'b1;
                wready <= 1'b0;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            if (do_write)
            begin
                bvalid <= 1'b1;
                bresp <= cur_word[32] ? `RESP_SLVERR : `RESP_OKAY;
            end
            if (bvalid & bready)
            begin
                bvalid <= 1'b0;
                aw_held <= 1'b0;
                w_held <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
            if (arvalid & arready)
            begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                // slverr is 2'b10, so the miss flag lands in the upper response bit
                {rresp[1], rdata} <= read_word(araddr);
                rresp[0] <= 1'b0;
            end
            if (rvalid & rready)
            begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // ****************************************
    // settings, status and interrupt
    // ****************************************
    always @(posedge clock)
    begin
        if (reset)
        begin
            trigger_on <= 1'b0;
            width_mode <= 1'b0;
            sensor_8k <= 1'b0;
            link_cfg <= `LINK_BASE;
            pixel_fmt <= `colour_8bit_format;
            line_period <= `RESET_LINE_PERIOD;
            exposure <= `RESET_EXPOSURE;
            status <= {`STATUS_W{1'b0}};
            mask <= {`STATUS_W{1'b0}};
            irq <= 1'b0;
        end
        else if (enable)
        begin
            if (wr_control)
            begin
                trigger_on <= merged[`CTRL_TRIGGER];
                // width mode cannot be held without triggering
                width_mode <= merged[`CTRL_WIDTH] & merged[`CTRL_TRIGGER];
                link_cfg <= merged[`CTRL_LINK_LSB +: 2];
                pixel_fmt <= merged[`CTRL_FORMAT_LSB +: 2];
                sensor_8k <= merged[`CTRL_SENSOR_8K];
            end
            if (wr_period & period_ok)
            begin
                line_period <= new_val;
                exposure <= exposure_fit;
            end
            if (wr_exposure & exposure_ok)
                exposure <= new_val;
            if (do_write & (waddr == `OFF_MASK))
                mask <= merged[`STATUS_W-1:0];
            status <= next_status;
            irq <= |(next_status & mask);
        end
    end

    // ****************************************
    // line sync sampling and exposure engine
    // ****************************************
    always @(posedge clock)
    begin
        if (reset)
        begin
            sync_meta <= 1'b0;
            sync_s <= 1'b0;
            sync_prev <= 1'b0;
            pending <= 1'b0;
            exp_count <= {PERIOD_W{1'b0}};
            period_count <= {PERIOD_W{1'b0}};
            since_line <= {PERIOD_W{1'b0}};
            exposure_active <= 1'b0;
            line_start <= 1'b0;
            readout_start <= 1'b0;
        end
        else if (enable)
        begin
            sync_meta <= line_sync_input;
            sync_s <= sync_meta;
            sync_prev <= sync_s;
            line_start <= ev_line;
            readout_start <= ev_readout;
            if (wr_control)
            begin
                // a mode change abandons the line in flight
                pending <= 1'b0;
                exposure_active <= 1'b0;
                period_count <= {PERIOD_W{1'b0}};
                line_start <= 1'b0;
                readout_start <= 1'b0;
            end
            else
            begin
                period_count <= (free_run & ~free_start) ?
                                period_count + 1'b1 : {PERIOD_W{1'b0}};
                if (timed_start)
                    pending <= pending & fall;
                else if (timed_ext & fall)
                    pending <= 1'b1;
                else if (~timed_ext)
                    pending <= 1'b0;
                if (ev_line)
                begin
                    exposure_active <= 1'b1;
                    exp_count <= exposure;
                end
                else if (ev_readout)
                    exposure_active <= 1'b0;
                else if (exposure_active)
                    exp_count <= exp_count - 1'b1;
            end
            if (ev_line)
                since_line <= {PERIOD_W{1'b0}};
            else if (~&since_line)
                since_line <= since_line + 1'b1;
        end
    end

endmodule // line_exposure_timing

// [exposure_monitor.sv]
// assertion checker for the line exposure timing block
`timescale 1ns/10ps
module exposure_monitor (
    // clock and reset
    input logic clock,
    input logic reset,
    // register bus
    input logic awvalid,
    input logic awready,
    input logic wvalid,
    input logic wready,
    input logic bvalid,
    input logic bready,
    input logic [1:0] bresp,
    input logic [7:0] araddr,
    input logic arvalid,
    input logic arready,
    input logic rvalid,
    input logic rready,
    input logic [1:0] rresp,
    input logic [31:0] rdata,
    // sensor timing
    input logic exposure_active,
    input logic line_start,
    input logic readout_start
);
    // ********
    // line spacing counter
    // ********
    // any write may restart the engine, so spacing is not judged across one
    logic [9:0] gap;
    always @(posedge clock)
    begin
        if (reset || (awvalid && awready))
            gap <= 10'h3ff;
        else if (line_start)
            gap <= 10'h000;
        else if (gap != 10'h3ff)
            gap <= gap + 10'h001;
    end
    default clocking mon_clk @(posedge clock); endclocking
    default disable iff (reset);
    a_line_spacing: assert property (line_start |-> gap >= 10'h1fb)
        else $error("line start inside readout period");
    a_line_pulse: assert property (line_start |=> !line_start)
        else $error("line start longer than one cycle");
    a_exposure_begins: assert property (line_start |-> exposure_active)
        else $error("line start without exposure");
    a_readout_ends: assert property (readout_start |-> !exposure_active ##1 !readout_start)
        else $error("readout pulse wrong");
    a_no_overlap: assert property (line_start |-> !$past(exposure_active))
        else $error("line started during exposure");
    a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    a_unmapped_read: assert property (arvalid && arready && araddr >= 8'h18
        |=> rvalid && rresp == 2'h2 && rdata == 32'h0)
        else $error("unmapped read not refused");
    a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write not answered");
endmodule // exposure_monitor

bind line_exposure_timing exposure_monitor i_mon (
    .clock(clock), .reset(reset), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rvalid(rvalid), .rready(rready), .rresp(rresp), .rdata(rdata),
    .exposure_active(exposure_active), .line_start(line_start),
    .readout_start(readout_start));

// [frame_grabber_model.sv]
// frame grabber model driving the line sync control line
`timescale 1ns/10ps
module frame_grabber_model (
    // clock
    input wire clock,
    // first camera control line
    output reg line_sync_input
);
    initial line_sync_input = 1'h0;
    // callers keep high above 100 and low above 50 cycles in width mode
    task automatic pulse(input int hi, input int lo);
        line_sync_input <= 1'h1;
        repeat (hi) @(posedge clock);
        line_sync_input <= 1'h0;
        repeat (lo) @(posedge clock);
    endtask
endmodule // frame_grabber_model

// [tb.sv]
// self-checking bench for the line exposure timing block
`timescale 1ns/10ps
module tb;
    logic clock = 1'h0;
    logic reset = 1'h1;
    logic enable = 1'h1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    wire line_sync_input, awready, wready, bvalid, arready, rvalid;
    wire exposure_active, line_start, readout_start, irq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    int err_total = 0;
    int checks = 0;
    int n;
    logic [6:0] ctl [12] = '{7'h40, 7'h44, 7'h54, 7'h48, 7'h78, 7'h4c, 7'h6c,
        7'h00, 7'h04, 7'h14, 7'h08, 7'h0c};
    logic [11:0] cap [12] = '{12'h9c4, 12'h4e2, 12'h43f, 12'h39e, 12'h209, 12'h2e0,
        12'h209, 12'h4e2, 12'h271, 12'h220, 12'h209, 12'h209};
    always #20 clock = ~clock;
    line_exposure_timing #(.LINE_PERIOD_MAX(25'h1388), .EXPOSURE_MAX(25'h7d0)) i_dut (
        .clock(clock), .reset(reset), .enable(enable), .line_sync_input(line_sync_input),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .exposure_active(exposure_active), .line_start(line_start),
        .readout_start(readout_start), .irq(irq));
    frame_grabber_model i_fg (.clock(clock), .line_sync_input(line_sync_input));
    // ********
    // shared tasks
    // ********
    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do
        begin
            @(posedge clock);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end
        while (bvalid !== 1'h1);
        bready <= 1'h0;
        chk("bresp", 32'h0, {30'h0, bresp});
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do
        begin
            @(posedge clock);
            if (arready) arvalid <= 1'h0;
        end
        while (rvalid !== 1'h1);
        rready <= 1'h0;
        d = rdata;
        r = rresp;
    endtask
    task automatic rc(input string w, input logic [7:0] a, input logic [31:0] e,
        input logic [31:0] m = 32'hffffffff);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(w, e, d & m);
    endtask
    // counts edges until line_start (sel 0) or readout_start (sel 1) is seen
    task automatic cnt_to(input bit sel, input int lim, output int k);
        k = 0;
        do
        begin
            @(posedge clock);
            k++;
        end
        while ((sel ? readout_start : line_start) !== 1'h1 && k < lim);
    endtask
    // ********
    // scenarios
    // ********
    task automatic t_defaults();
        logic [31:0] d;
        logic [1:0] r;
        rc("control", 8'h00, 32'h0);
        rc("exposure", 8'h08, 32'h3e8);
        rc("status", 8'h0c, 32'h0);
        rd(8'h18, d, r);
        chk("unmapped resp", 32'h2, {30'h0, r});
        chk("unmapped data", 32'h0, d);
    endtask
    task automatic t_free_run();
        wr(8'h04, 32'h514);
        cnt_to(0, 3000, n);
        chk("free line", 32'h1, 32'(n < 3000));
        cnt_to(1, 3000, n);
        chk("exposure cycles", 32'h3e8, n);
        cnt_to(0, 3000, n);
        chk("rest of period", 32'h12c, n);
        // a frozen engine delays the next line by the frozen edges
        enable <= 1'h0;
        repeat (100) @(posedge clock);
        enable <= 1'h1;
        cnt_to(0, 3000, n);
        chk("frozen period", 32'h514, n);
        wr(8'h04, 32'h4e1);
        rc("period below cap", 8'h04, 32'h514);
        rc("invalid flag", 8'h0c, 32'h4, 32'h4);
    endtask
    task automatic t_limits();
        wr(8'h00, 32'h8);
        wr(8'h08, 32'h4a6);
        rc("exposure in range", 8'h08, 32'h4a6);
        wr(8'h04, 32'h258);
        rc("exposure clamped", 8'h08, 32'h225);
        wr(8'h08, 32'h230);
        rc("exposure too long", 8'h08, 32'h225);
        wr(8'h04, 32'h208);
        rc("rate above max", 8'h04, 32'h258);
        wr(8'h04, 32'h1389);
        rc("rate below min", 8'h04, 32'h258);
        wr(8'h08, 32'h63);
        rc("exposure too short", 8'h08, 32'h225);
        wr(8'h08, 32'h64);
        rc("exposure minimum", 8'h08, 32'h64);
    endtask
    task automatic t_caps();
        for (int i = 0; i < 12; i++)
        begin
            wr(8'h00, {25'h0, ctl[i]});
            wr(8'h04, {20'h0, cap[i]});
            wr(8'h04, {20'h0, cap[i] - 12'h1});
            rc("rate cap", 8'h04, {20'h0, cap[i]});
        end
    endtask
    task automatic t_lock();
        wr(8'h00, 32'h2);
        rc("width without trigger", 8'h00, 32'h0);
        wr(8'h00, 32'h9);
        wr(8'h04, 32'h3e8);
        rc("period while triggered", 8'h04, 32'h209);
        wr(8'h00, 32'hb);
        rc("width with trigger", 8'h00, 32'hb);
        wr(8'h08, 32'h12c);
        rc("exposure in width mode", 8'h08, 32'h64);
    endtask
    task automatic t_timed();
        wr(8'h00, 32'h8);
        wr(8'h08, 32'h12c);
        wr(8'h00, 32'h9);
        // let the minimum line spacing lapse before the first edge
        repeat (600) @(posedge clock);
        wr(8'h0c, 32'hf);
        fork
            begin
                i_fg.pulse(20, 20);
                i_fg.pulse(20, 20);
                i_fg.pulse(20, 900);
            end
            begin
                cnt_to(0, 200, n);
                chk("fall starts line", 32'h1, 32'(n < 200));
                cnt_to(1, 400, n);
                chk("timed exposure", 32'h12c, n);
                cnt_to(0, 400, n);
                chk("latched fall", 32'h1, 32'(n < 400));
                cnt_to(1, 400, n);
                chk("latched exposure", 32'h12c, n);
                cnt_to(0, 600, n);
                chk("third fall dropped", 32'h258, n);
            end
        join
        rc("drop flag", 8'h0c, 32'h8, 32'h8);
    endtask
    task automatic t_width();
        wr(8'h00, 32'hb);
        wr(8'h0c, 32'hf);
        fork
            begin
                i_fg.pulse(400, 200);
                i_fg.pulse(150, 60);
                i_fg.pulse(150, 400);
            end
            begin
                cnt_to(0, 200, n);
                chk("rise starts line", 32'h1, 32'(n < 200));
                cnt_to(1, 600, n);
                chk("width exposure", 32'h190, n);
                cnt_to(0, 600, n);
                chk("second rise", 32'h1, 32'(n < 600));
                cnt_to(1, 600, n);
                chk("second width", 32'h96, n);
                cnt_to(0, 700, n);
                chk("fast rise dropped", 32'h2bc, n);
            end
        join
        rc("over-speed flag", 8'h0c, 32'h8, 32'h8);
    endtask
    task automatic t_irq();
        wr(8'h0c, 32'hf);
        wr(8'h10, 32'h0);
        wr(8'h08, 32'h12c);
        repeat (2) @(posedge clock);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(8'h10, 32'h4);
        repeat (2) @(posedge clock);
        chk("irq raised", 32'h1, {31'h0, irq});
        wr(8'h0c, 32'h4);
        repeat (2) @(posedge clock);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rc("state modes", 8'h14, 32'h3, 32'h3);
    endtask
    task automatic complete_run();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ********
    // main sequence and watchdog
    // ********
    initial
    begin
        repeat (16) @(posedge clock);
        reset <= 1'h0;
        t_defaults();
        t_free_run();
        t_limits();
        t_caps();
        t_lock();
        t_timed();
        t_width();
        t_irq();
        complete_run();
    end
    initial
    begin
        repeat (20000) @(posedge clock);
        err_total++;
        complete_run();
    end
endmodule // tb
